// File: dv/ocm_far_end_model.sv
// Far-end modem model: echoes the aggregate stream back as receive traffic
`timescale 1ns/1ps
module ocm_far_end_model (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Aggregate stream from the near end
  input wire logic i_agg_tick,
  input wire logic i_agg_bit,
  // Aggregate stream back to the near end
  output logic o_rx_tick,
  output logic o_rx_bit
);
  logic tick_q;
  logic tick_d;
  logic bit_q;
  logic bit_d;

  always_comb begin
    tick_d = i_agg_tick;
    // Line toggles between bits so a stale value never passes as data
    bit_d = i_agg_tick ? i_agg_bit : ~bit_q;
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tick_q <= 1'b0;
      bit_q <= 1'b0;
    end else begin
      tick_q <= tick_d;
      bit_q <= bit_d;
    end
  end

  assign o_rx_tick = tick_q;
  assign o_rx_bit = bit_q;
endmodule

// File: dv/testbench.sv
// Self-checking bench of the overhead channel multiplexer in far-end loopback
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin failures++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module testbench;
  import ocm_pkg::*;
  localparam logic [31:0] THRU = 32'h2000_0000;
  logic i_clock;
  logic i_rst_n;
  ocm_cfg_type cfg;
  logic [2:0] fec;
  logic [31:0] thru;
  logic tx_bit;
  logic svc_in;
  logic mcc_in;
  logic [1:0] aux_in;
  logic tx_take, agg_tick, agg_bit, rx_tick, rx_bit;
  logic [31:0] agg_inc;
  logic rx_data, rx_valid, rx_locked;
  logic svc_out, svc_oe, svc_rs485, svc_in_en, mcc_bit, mcc_valid;
  logic [1:0] aux_relay;
  ocm_mode_type mode;
  logic refused;
  ocm_ratio_type ratio;
  int failures = 0;
  int n_compared = 0;
  int cycles = 0;
  int loads[16] = '{240, 200, 160, 120, 96, 80, 64, 48, 40, 32, 24, 16, 12, 8, 6, 4};

  ocm_overhead_mux #(.HOLD_CYC(4)) i_ocm_overhead_mux (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_cfg(cfg), .i_fec_type(fec),
    .i_thru_rate_inc(thru), .i_tx_bit(tx_bit), .o_tx_take(tx_take),
    .o_agg_tick(agg_tick), .o_agg_bit(agg_bit), .o_agg_rate_inc(agg_inc),
    .i_rx_tick(rx_tick), .i_rx_bit(rx_bit), .o_rx_data(rx_data),
    .o_rx_valid(rx_valid), .o_rx_locked(rx_locked), .i_svc_in(svc_in),
    .o_svc_out(svc_out), .o_svc_out_oe(svc_oe), .o_svc_rs485(svc_rs485),
    .o_svc_in_en(svc_in_en), .i_mcc_bit(mcc_in), .o_mcc_bit(mcc_bit),
    .o_mcc_valid(mcc_valid), .i_aux_in(aux_in), .o_aux_relay(aux_relay),
    .o_mode(mode), .o_mode_refused(refused), .o_ratio(ratio)
  );

  ocm_far_end_model i_ocm_far_end_model (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_agg_tick(agg_tick),
    .i_agg_bit(agg_bit), .o_rx_tick(rx_tick), .o_rx_bit(rx_bit)
  );

  initial begin
    i_clock = 1'b0;
    forever #4 i_clock = ~i_clock;
  end

  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Run is far shorter; the ceiling only catches a hang
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 90000) begin
      failures++;
      end_sim();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask

  task automatic t_reset();
    `CHK(mode, OCM_MODE_DISABLED)
    `CHK(ratio, {9'h001, 8'h01})
    `CHK(aux_relay, 2'h0)
    `CHK(svc_oe, 1'b0)
    $display("test reset done");
  endtask

  task automatic t_standard();
    cfg.rs485 = 1'b1;
    cfg.tx_four_wire = 1'b0;
    cfg.rx_four_wire = 1'b0;
    cfg.mode = OCM_MODE_STANDARD;
    cyc(3);
    `CHK(mode, OCM_MODE_STANDARD)
    `CHK(ratio, {9'h010, 8'h0F})
    `CHK(svc_oe, 1'b1)
    `CHK(svc_in_en, 1'b1)
    `CHK(svc_rs485, 1'b1)
    cyc(80);
    `CHK(agg_inc, THRU + THRU / 32'd15)
    cfg.rs485 = 1'b0;
    cfg.mode = OCM_MODE_DISABLED;
    cyc(3);
    `CHK(ratio, {9'h001, 8'h01})
    `CHK(svc_oe, 1'b0)
    `CHK(svc_in_en, 1'b0)
    `CHK(svc_rs485, 1'b0)
    cyc(80);
    `CHK(agg_inc, THRU)
    $display("test standard done");
  endtask

  task automatic t_advanced();
    for (int f = 0; f < 8; f++) begin
      cfg.mode = OCM_MODE_STANDARD;
      cyc(2);
      fec = f[2:0];
      cfg.mode = OCM_MODE_ADVANCED;
      cyc(2);
      if (f == 4 || f == 5) begin
        `CHK(mode, OCM_MODE_ADVANCED)
        `CHK(refused, 1'b0)
      end else begin
        `CHK(mode, OCM_MODE_STANDARD)
        `CHK(refused, 1'b1)
      end
    end
    fec = 3'h0;
    $display("test advanced done");
  endtask

  task automatic t_rates();
    logic [31:0] ld;
    cfg.mode = OCM_MODE_CUSTOM;
    cfg.async_auto = 1'b1;
    cfg.mux_service_rate = 4'h0;
    for (int r = 0; r < 16; r++) begin
      cfg.async_rate = r[3:0];
      ld = loads[r];
      cyc(80);
      `CHK(ratio, {ld[8:0] + 9'h001, ld[7:0]})
      `CHK(agg_inc, THRU + THRU / ld)
    end
    // Manual takes the tighter of the two rates
    cfg.async_auto = 1'b0;
    cfg.async_rate = 4'h0;
    cfg.mux_service_rate = 4'hF;
    cyc(80);
    `CHK(ratio, {9'h005, 8'h04})
    `CHK(agg_inc, THRU + THRU / 32'd4)
    thru = 32'h1234_5678;
    cyc(80);
    `CHK(agg_inc, thru + thru / 32'd4)
    thru = THRU;
    $display("test rates done");
  endtask

  task automatic t_loop();
    int k;
    int seen;
    int takes;
    for (k = 0; k < 8000 && rx_locked !== 1'b1; k++) cyc(1);
    `CHK(rx_locked, 1'b1)
    for (int v = 0; v < 2; v++) begin
      tx_bit = v[0];
      mcc_in = v[0];
      aux_in = v[0] ? 2'b01 : 2'b10;
      cyc(1200);
      `CHK(aux_relay, aux_in)
      seen = 0;
      for (k = 0; k < 600; k++) begin
        if (rx_valid === 1'b1) begin
          seen++;
          `CHK(rx_data, v[0])
        end
        if (mcc_valid === 1'b1) begin
          `CHK(mcc_bit, v[0])
        end
        cyc(1);
      end
      `CHK(seen > 0, 1'b1)
    end
    // One received frame spans exactly the data takes of one sent frame
    for (k = 0; k < 2000 && mcc_valid !== 1'b1; k++) cyc(1);
    takes = 0;
    for (k = 0; k < 2000; k++) begin
      cyc(1);
      if (mcc_valid === 1'b1) break;
      if (tx_take === 1'b1) takes++;
    end
    `CHK(takes, 8 * loads[15])
    $display("test loopback done");
  endtask

  task automatic t_two_wire();
    int k;
    cfg.rs485 = 1'b1;
    svc_in = 1'b1;
    cyc(600);
    `CHK(svc_oe, 1'b0)
    `CHK(svc_in_en, 1'b1)
    svc_in = 1'b0;
    for (k = 0; k < 3000 && svc_out !== 1'b0; k++) cyc(1);
    `CHK(svc_out, 1'b0)
    cyc(3);
    `CHK(svc_oe, 1'b1)
    `CHK(svc_in_en, 1'b0)
    cfg.tx_four_wire = 1'b1;
    cfg.rx_four_wire = 1'b1;
    cyc(600);
    `CHK(svc_oe, 1'b1)
    `CHK(svc_in_en, 1'b1)
    $display("test two wire done");
  endtask

  initial begin
    cfg = '0;
    fec = 3'h0;
    thru = THRU;
    tx_bit = 1'b0;
    svc_in = 1'b1;
    mcc_in = 1'b0;
    aux_in = 2'b00;
    i_rst_n = 1'b0;
    cyc(16);
    i_rst_n = 1'b1;
    cyc(1);
    t_reset();
    t_standard();
    t_advanced();
    t_rates();
    t_loop();
    t_two_wire();
    end_sim();
  end
endmodule

// File: hw/ocm_overhead_mux.sv
// Overhead channel multiplexer and demultiplexer for the aggregate stream
`timescale 1ns/1ps
module ocm_overhead_mux #(
  parameter int HOLD_CYC = ocm_pkg::OCM_SVC_HOLD_CYC
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Configuration
  input wire ocm_pkg::ocm_cfg_type i_cfg,
  input wire logic [2:0] i_fec_type,
  input wire logic [ocm_pkg::OCM_INC_W-1:0] i_thru_rate_inc,
  // Terrestrial transmit data
  input wire logic i_tx_bit,
  output logic o_tx_take,
  // Aggregate transmit stream
  output logic o_agg_tick,
  output logic o_agg_bit,
  output logic [ocm_pkg::OCM_INC_W-1:0] o_agg_rate_inc,
  // Aggregate receive stream and recovered data
  input wire logic i_rx_tick,
  input wire logic i_rx_bit,
  output logic o_rx_data,
  output logic o_rx_valid,
  output logic o_rx_locked,
  // Service channel pins
  input wire logic i_svc_in,
  output logic o_svc_out,
  output logic o_svc_out_oe,
  output logic o_svc_rs485,
  output logic o_svc_in_en,
  // Modem control channel
  input wire logic i_mcc_bit,
  output logic o_mcc_bit,
  output logic o_mcc_valid,
  // Auxiliary one-bit channels
  input wire logic [1:0] i_aux_in,
  output logic [1:0] o_aux_relay,
  // Status
  output ocm_pkg::ocm_mode_type o_mode,
  output logic o_mode_refused,
  output ocm_pkg::ocm_ratio_type o_ratio
);
  import ocm_pkg::*;

  if (HOLD_CYC < 1 || HOLD_CYC > 65535) begin : g_check
    $error("HOLD_CYC out of range");
  end

  // Pin synchronisers
  logic [2:0] sync1_q, sync2_q;
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync1_q <= 3'h7;
      sync2_q <= 3'h7;
    end else begin
      sync1_q <= {i_aux_in, i_svc_in};
      sync2_q <= sync1_q;
    end
  end

  // Mode, load and ratio
  ocm_mode_type mode_q, mode_d;
  logic refused_q, refused_d;
  logic [OCM_LOAD_W-1:0] load_q, load_d, mux_load;
  ocm_ratio_type ratio_q, ratio_d;
  logic full_ch;
  always_comb begin
    refused_d = (i_cfg.mode == OCM_MODE_ADVANCED) &&
                (i_fec_type != OCM_FEC_TPC) && (i_fec_type != OCM_FEC_LDPC);
    mode_d = refused_d ? mode_q : i_cfg.mode;
    mux_load = ocm_rate_load(i_cfg.mux_service_rate);
    load_d = ocm_rate_load(i_cfg.async_rate);
    if (!i_cfg.async_auto && mux_load < load_d) begin
      load_d = mux_load;
    end
    if (mode_d == OCM_MODE_STANDARD) begin
      load_d = OCM_STD_LOAD;
    end
    if (mode_d == OCM_MODE_DISABLED) begin
      // Load 0 marks disabled mode; the divider then passes the rate 1/1
      load_d = '0;
      ratio_d = '{num: 9'h001, den: 8'h01};
    end else begin
      ratio_d = '{num: {1'b0, load_d} + 9'h001, den: load_d};
    end
  end
  assign full_ch = (mode_q == OCM_MODE_CUSTOM) || (mode_q == OCM_MODE_ADVANCED);
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mode_q <= OCM_RST_MODE;
      refused_q <= 1'b0;
      load_q <= OCM_STD_LOAD;
      ratio_q <= '{num: 9'h001, den: 8'h01};
    end else begin
      mode_q <= mode_d;
      refused_q <= refused_d;
      load_q <= load_d;
      ratio_q <= ratio_d;
    end
  end

  // Aggregate increment = through + through/load, by serial division
  logic busy_q, busy_d;
  logic [5:0] step_q, step_d;
  logic [OCM_LOAD_W:0] rem_q, rem_d, rem_sh;
  logic [OCM_INC_W-1:0] num_q, num_d, quo_q, quo_d, src_q, src_d, inc_q, inc_d;
  logic [OCM_LOAD_W-1:0] dload_q, dload_d;
  always_comb begin
    busy_d = busy_q;
    step_d = step_q;
    rem_d = rem_q;
    num_d = num_q;
    quo_d = quo_q;
    src_d = src_q;
    dload_d = dload_q;
    inc_d = inc_q;
    rem_sh = {rem_q[OCM_LOAD_W-1:0], num_q[OCM_INC_W-1]};
    if (!busy_q && (i_thru_rate_inc != src_q || load_q != dload_q)) begin
      busy_d = 1'b1;
      step_d = 6'h00;
      rem_d = '0;
      num_d = i_thru_rate_inc;
      src_d = i_thru_rate_inc;
      dload_d = load_q;
    end else if (busy_q) begin
      num_d = {num_q[OCM_INC_W-2:0], 1'b0};
      if (rem_sh >= {1'b0, dload_q}) begin
        rem_d = rem_sh - {1'b0, dload_q};
        quo_d = {quo_q[OCM_INC_W-2:0], 1'b1};
      end else begin
        rem_d = rem_sh;
        quo_d = {quo_q[OCM_INC_W-2:0], 1'b0};
      end
      step_d = step_q + 6'h01;
      if (step_d == OCM_DIV_STEPS) begin
        busy_d = 1'b0;
        inc_d = (dload_q == '0) ? src_q : src_q + quo_d;
      end
    end
  end
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      busy_q <= 1'b0;
      step_q <= 6'h00;
      rem_q <= '0;
      num_q <= '0;
      quo_q <= '0;
      src_q <= '0;
      dload_q <= '0;
      inc_q <= '0;
    end else begin
      busy_q <= busy_d;
      step_q <= step_d;
      rem_q <= rem_d;
      num_q <= num_d;
      quo_q <= quo_d;
      src_q <= src_d;
      dload_q <= dload_d;
      inc_q <= inc_d;
    end
  end

  // Service channel direction control
  logic svc_out_q, svc_out_d, oe_q, oe_d, in_en_q, in_en_d, rs485_q, rs485_d;
  logic [15:0] hold_q, hold_d;
  logic drv_active, mute, svc_in_eff;
  assign drv_active = !svc_out_q || (hold_q != 16'h0000);
  // Standard mode has no two-wire option
  assign mute = full_ch && !i_cfg.rx_four_wire && drv_active;
  assign svc_in_eff = mute ? 1'b1 : sync2_q[0];

  // Transmit framing and aggregate rate generator
  logic [OCM_INC_W-1:0] acc_q, acc_d;
  logic carry;
  logic [OCM_POS_W-1:0] tpos_q, tpos_d, frame_last;
  logic tick_q, abit_q, abit_d, take_q, take_d, tx_data_slot;
  logic [3:0] tx_payload;
  assign frame_last = OCM_POS_W'({load_q, 3'b000} + 11'd7);
  always_comb begin
    {carry, acc_d} = {1'b0, acc_q} + {1'b0, inc_q};
    tx_data_slot = (mode_q == OCM_MODE_DISABLED) || (tpos_q >= OCM_POS_W'(OCM_OVH_BITS));
    if (full_ch) begin
      tx_payload = {svc_in_eff, i_mcc_bit, sync2_q[2:1]};
    end else begin
      tx_payload = {4{svc_in_eff}};
    end
    tpos_d = tpos_q;
    abit_d = abit_q;
    take_d = 1'b0;
    if (carry) begin
      if (tx_data_slot) begin
        abit_d = i_tx_bit;
        take_d = 1'b1;
      end else if (tpos_q < OCM_POS_W'(OCM_SYNC_BITS)) begin
        abit_d = OCM_SYNC_NIBBLE[3 - tpos_q[1:0]];
      end else begin
        abit_d = tx_payload[3 - tpos_q[1:0]];
      end
      if (mode_q == OCM_MODE_DISABLED || tpos_q >= frame_last) begin
        tpos_d = '0;
      end else begin
        tpos_d = tpos_q + 12'h001;
      end
    end
  end
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      acc_q <= '0;
      tpos_q <= '0;
      tick_q <= 1'b0;
      abit_q <= 1'b1;
      take_q <= 1'b0;
    end else begin
      acc_q <= acc_d;
      tpos_q <= tpos_d;
      tick_q <= carry;
      abit_q <= abit_d;
      take_q <= take_d;
    end
  end

  // Receive alignment and overhead extraction
  ocm_align_type st_q, st_d;
  logic [3:0] sh_q, sh_d;
  logic [OCM_POS_W-1:0] rpos_q, rpos_d;
  logic [1:0] hits_q, hits_d, miss_q, miss_d, aux_q, aux_d;
  logic rdat_q, rdat_d, rval_q, rval_d, lock_q, lock_d, mccb_q, mccb_d, mccv_q, mccv_d;
  always_comb begin
    st_d = st_q;
    sh_d = sh_q;
    rpos_d = rpos_q;
    hits_d = hits_q;
    miss_d = miss_q;
    aux_d = aux_q;
    rdat_d = rdat_q;
    rval_d = 1'b0;
    mccb_d = mccb_q;
    mccv_d = 1'b0;
    svc_out_d = svc_out_q;
    if (i_rx_tick) begin
      sh_d = {sh_q[2:0], i_rx_bit};
      rdat_d = i_rx_bit;
      rpos_d = (rpos_q >= frame_last) ? '0 : rpos_q + 12'h001;
      if (mode_q == OCM_MODE_DISABLED) begin
        rval_d = 1'b1;
        st_d = OCM_ALIGN_HUNT;
      end else begin
        case (st_q)
          OCM_ALIGN_HUNT: begin
            if (sh_d == OCM_SYNC_NIBBLE) begin
              st_d = OCM_ALIGN_VERIFY;
              hits_d = 2'h1;
              rpos_d = OCM_POS_W'(OCM_SYNC_BITS);
            end
          end
          OCM_ALIGN_VERIFY: begin
            if (rpos_q == OCM_POS_W'(OCM_SYNC_BITS - 1)) begin
              if (sh_d != OCM_SYNC_NIBBLE) begin
                st_d = OCM_ALIGN_HUNT;
              end else begin
                hits_d = hits_q + 2'h1;
                if (hits_d == OCM_LOCK_HITS) begin
                  st_d = OCM_ALIGN_LOCKED;
                  miss_d = 2'h0;
                end
              end
            end
          end
          OCM_ALIGN_LOCKED: begin
            if (rpos_q == OCM_POS_W'(OCM_SYNC_BITS - 1)) begin
              miss_d = (sh_d == OCM_SYNC_NIBBLE) ? 2'h0 : miss_q + 2'h1;
              if (miss_d == OCM_LOCK_MISSES) begin
                st_d = OCM_ALIGN_HUNT;
              end
            end else if (rpos_q >= OCM_POS_W'(OCM_OVH_BITS)) begin
              rval_d = 1'b1;
            end else if (rpos_q < OCM_POS_W'(OCM_SYNC_BITS)) begin
              // Sync bits carry no payload
              rval_d = 1'b0;
            end else if (full_ch) begin
              case (rpos_q[1:0])
                2'd0: svc_out_d = i_rx_bit;
                2'd1: begin
                  mccb_d = i_rx_bit;
                  mccv_d = 1'b1;
                end
                default: aux_d[3 - rpos_q[1:0]] = i_rx_bit;
              endcase
            end else begin
              svc_out_d = i_rx_bit;
            end
          end
          default: st_d = OCM_ALIGN_HUNT;
        endcase
      end
    end
    lock_d = (mode_q == OCM_MODE_DISABLED) || (st_d == OCM_ALIGN_LOCKED);
    hold_d = !svc_out_q ? 16'(HOLD_CYC) : (hold_q != 16'h0000 ? hold_q - 16'h0001 : hold_q);
    rs485_d = i_cfg.rs485;
    // Disabled mode has no service channel: output driver and input are both off
    if (mode_q == OCM_MODE_DISABLED) begin
      oe_d = 1'b0;
      in_en_d = 1'b0;
    end else begin
      oe_d = !i_cfg.rs485 || i_cfg.tx_four_wire || !full_ch || drv_active;
      in_en_d = !mute;
    end
  end
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= OCM_ALIGN_HUNT;
      sh_q <= 4'h0;
      rpos_q <= '0;
      hits_q <= 2'h0;
      miss_q <= 2'h0;
      aux_q <= 2'h0;
      rdat_q <= 1'b0;
      rval_q <= 1'b0;
      lock_q <= 1'b0;
      mccb_q <= 1'b0;
      mccv_q <= 1'b0;
      svc_out_q <= 1'b1;
      hold_q <= 16'h0000;
      oe_q <= 1'b0;
      in_en_q <= 1'b0;
      rs485_q <= 1'b0;
    end else begin
      st_q <= st_d;
      sh_q <= sh_d;
      rpos_q <= rpos_d;
      hits_q <= hits_d;
      miss_q <= miss_d;
      aux_q <= aux_d;
      rdat_q <= rdat_d;
      rval_q <= rval_d;
      lock_q <= lock_d;
      mccb_q <= mccb_d;
      mccv_q <= mccv_d;
      svc_out_q <= svc_out_d;
      hold_q <= hold_d;
      oe_q <= oe_d;
      in_en_q <= in_en_d;
      rs485_q <= rs485_d;
    end
  end

  assign o_tx_take = take_q;
  assign o_agg_tick = tick_q;
  assign o_agg_bit = abit_q;
  assign o_agg_rate_inc = inc_q;
  assign o_rx_data = rdat_q;
  assign o_rx_valid = rval_q;
  assign o_rx_locked = lock_q;
  assign o_svc_out = svc_out_q;
  assign o_svc_out_oe = oe_q;
  assign o_svc_rs485 = rs485_q;
  assign o_svc_in_en = in_en_q;
  assign o_mcc_bit = mccb_q;
  assign o_mcc_valid = mccv_q;
  assign o_aux_relay = aux_q;
  assign o_mode = mode_q;
  assign o_mode_refused = refused_q;
  assign o_ratio = ratio_q;

  // Checks
  sequence s_std_settled;
    (mode_q == OCM_MODE_STANDARD) [*2];
  endsequence
  property p_ratio_std;
    @(posedge i_clock) disable iff (!i_rst_n)
      s_std_settled |-> (o_ratio.num == 9'h010) && (o_ratio.den == 8'h0F);
  endproperty
  a_ratio_std: assert property (p_ratio_std) else $error("standard ratio not 16/15");
  property p_ratio_off;
    @(posedge i_clock) disable iff (!i_rst_n)
      (mode_q == OCM_MODE_DISABLED) [*2] |-> (o_ratio.num == 9'h001) && (o_ratio.den == 8'h01);
  endproperty
  a_ratio_off: assert property (p_ratio_off) else $error("disabled ratio not 1/1");
  property p_adv_refused;
    @(posedge i_clock) disable iff (!i_rst_n)
      (i_cfg.mode == OCM_MODE_ADVANCED && i_fec_type != OCM_FEC_TPC &&
       i_fec_type != OCM_FEC_LDPC)
        |=> o_mode_refused && (o_mode == $past(o_mode));
  endproperty
  a_adv_refused: assert property (p_adv_refused) else $error("advanced mode accepted");
  property p_pins_off;
    @(posedge i_clock) disable iff (!i_rst_n)
      (mode_q == OCM_MODE_DISABLED) |=> !o_svc_out_oe && !o_svc_in_en;
  endproperty
  a_pins_off: assert property (p_pins_off) else $error("service pins live while off");
  property p_std_four_wire;
    @(posedge i_clock) disable iff (!i_rst_n)
      (mode_q == OCM_MODE_STANDARD) ##1 (mode_q == OCM_MODE_STANDARD) |-> o_svc_out_oe;
  endproperty
  a_std_four_wire: assert property (p_std_four_wire) else $error("standard not 4-wire");
  property p_mute;
    @(posedge i_clock) disable iff (!i_rst_n)
      mute |-> svc_in_eff ##1 !o_svc_in_en;
  endproperty
  a_mute: assert property (p_mute) else $error("receive input not muted");
  property p_no_data_unlocked;
    @(posedge i_clock) disable iff (!i_rst_n)
      (st_q != OCM_ALIGN_LOCKED && mode_q != OCM_MODE_DISABLED) |=> !o_rx_valid;
  endproperty
  a_no_data_unlocked: assert property (p_no_data_unlocked) else $error("data before lock");
  property p_take;
    @(posedge i_clock) disable iff (!i_rst_n)
      carry && tx_data_slot |=> o_tx_take && o_agg_tick && (o_agg_bit == $past(i_tx_bit));
  endproperty
  a_take: assert property (p_take) else $error("data slot not taken");
  property p_no_mcc_std;
    @(posedge i_clock) disable iff (!i_rst_n)
      (mode_q == OCM_MODE_STANDARD) [*2] |-> !o_mcc_valid && $stable(o_aux_relay);
  endproperty
  a_no_mcc_std: assert property (p_no_mcc_std) else $error("control traffic in standard");
endmodule

// File: hw/ocm_pkg.sv
// Shared constants, types and helpers of the overhead channel multiplexer
package ocm_pkg;
  localparam int OCM_IDX_W = 4;
  localparam int OCM_LOAD_W = 8;
  localparam int OCM_INC_W = 32;
  localparam int OCM_POS_W = 12;
  localparam int OCM_OVH_BITS = 8;
  localparam int OCM_SYNC_BITS = 4;
  localparam logic [3:0] OCM_SYNC_NIBBLE = 4'hB;
  localparam logic [7:0] OCM_STD_LOAD = 8'h0F;
  localparam logic [2:0] OCM_FEC_TPC = 3'h4;
  localparam logic [2:0] OCM_FEC_LDPC = 3'h5;
  localparam logic [1:0] OCM_LOCK_HITS = 2'h3;
  localparam logic [1:0] OCM_LOCK_MISSES = 2'h2;
  localparam logic [5:0] OCM_DIV_STEPS = 6'h20;
  localparam int OCM_CLK_PERIOD_PS = 8000;
  localparam int OCM_SVC_HOLD_NS = 10000;
  localparam int OCM_SVC_HOLD_CYC = (OCM_SVC_HOLD_NS * 1000 + OCM_CLK_PERIOD_PS - 1)
                                    / OCM_CLK_PERIOD_PS;

  typedef enum logic [1:0] {
    OCM_MODE_DISABLED = 2'b00,
    OCM_MODE_STANDARD = 2'b01,
    OCM_MODE_CUSTOM = 2'b10,
    OCM_MODE_ADVANCED = 2'b11
  } ocm_mode_type;

  typedef enum logic [1:0] {
    OCM_ALIGN_HUNT = 2'b00,
    OCM_ALIGN_VERIFY = 2'b01,
    OCM_ALIGN_LOCKED = 2'b10
  } ocm_align_type;

  localparam ocm_mode_type OCM_RST_MODE = OCM_MODE_DISABLED;

  typedef struct packed {
    ocm_mode_type mode;
    logic rs485;
    logic tx_four_wire;
    logic rx_four_wire;
    logic async_auto;
    logic [OCM_IDX_W-1:0] async_rate;
    logic [OCM_IDX_W-1:0] mux_service_rate;
  } ocm_cfg_type;

  typedef struct packed {
    logic [OCM_LOAD_W:0] num;
    logic [OCM_LOAD_W-1:0] den;
  } ocm_ratio_type;

  // Data bytes per frame for each async rate, 300 bps up to 3.5 Mbps
  function automatic logic [OCM_LOAD_W-1:0] ocm_rate_load(input logic [OCM_IDX_W-1:0] idx);
    logic [OCM_LOAD_W-1:0] r;
    case (idx)
      4'h0: r = 8'hF0;
      4'h1: r = 8'hC8;
      4'h2: r = 8'hA0;
      4'h3: r = 8'h78;
      4'h4: r = 8'h60;
      4'h5: r = 8'h50;
      4'h6: r = 8'h40;
      4'h7: r = 8'h30;
      4'h8: r = 8'h28;
      4'h9: r = 8'h20;
      4'hA: r = 8'h18;
      4'hB: r = 8'h10;
      4'hC: r = 8'h0C;
      4'hD: r = 8'h08;
      4'hE: r = 8'h06;
      default: r = 8'h04;
    endcase
    return r;
  endfunction
endpackage
